/* tblwr_exec.sv */
// table-write execution: latch byte into holding buffer via pointer
// assumes instr_valid_i is a one-cycle pulse on a decode slot
// Operation
// - decode opcode, two-bit pointer mode field
// - post-decrement: write first, then subtract one
// - pre-increment: add one, write at new pointer
// - low pointer bits select holding register
// - writes reach holding registers only
// - pointer is 21-bit byte address
// - pointer bit zero clear selects low byte
// - pointer bit zero set selects high byte
// - one word, two cycles, read Q2, write Q4
`timescale 1ns/1ps
`include "tblwr_map.svh"
module tblwr_exec
(
   input wire logic sys_clk_i, // 25 MHz core clock
   input wire logic rst_n_i, // sync reset, active low
   input wire logic instr_valid_i, // instruction word present
   input wire logic [15:0] instr_word_i, // fetched instruction
   input wire logic [7:0] table_latch_byte_i, // latch byte
   input wire logic ptr_load_i, // software load of pointer
   input wire logic [`TBLWR_PTR_W-1:0] ptr_load_data_i, // load value
   input wire logic [`TBLWR_HOLD_AW-1:0] hold_rd_addr_i, // buffer peek
   output logic [7:0] hold_rd_data_o, // buffer byte
   output logic [`TBLWR_PTR_W-1:0] table_byte_pointer_o, // pointer
   output logic busy_o, // instruction in progress
   output logic hold_wr_o, // holding register written
   output logic hi_byte_o, // last write was high byte
   output logic flags_we_o // status write enable, always low
);
   tblwr_pkg::tblwr_state_type state;
   tblwr_pkg::tblwr_mode_type mode;
   logic [`TBLWR_PTR_W-1:0] ptr;
   logic [7:0] data_q;
   logic is_table_write_instr;
   logic [1:0] q;
   logic take;
   logic cyc1_first;
   logic latch_slot;
   logic [`TBLWR_HOLD_AW-1:0] hold_addr;

   // opcode match: fixed upper field, mode in the two low bits; every
   // upper bit counts, since neighbouring opcodes differ only there
   function automatic logic f_is_table_write(logic [15:0] word);
      logic hit;
      hit = word[15:2] == `TBLWR_OPC_FIXED;
      return hit;
   endfunction

   // mode field lifted into the enum
   function automatic tblwr_pkg::tblwr_mode_type f_mode(logic [15:0] word);
      tblwr_pkg::tblwr_mode_type m;
      m = tblwr_pkg::tblwr_mode_type'(word[1:0]);
      return m;
   endfunction

   // pre-increment moves the pointer in cycle one, ahead of the write
   function automatic logic [`TBLWR_PTR_W-1:0] f_pre_step
   (
      tblwr_pkg::tblwr_mode_type m,
      logic [`TBLWR_PTR_W-1:0] p
   );
      logic [`TBLWR_PTR_W-1:0] r;
      if (m == tblwr_pkg::TBLWR_PREINC)
         r = p + 21'h000001;
      else
         r = p;
      return r;
   endfunction

   // pointer after the holding write; it wraps at both ends of the
   // 21-bit space, as plain two's complement arithmetic does
   function automatic logic [`TBLWR_PTR_W-1:0] f_post_step
   (
      tblwr_pkg::tblwr_mode_type m,
      logic [`TBLWR_PTR_W-1:0] p
   );
      logic [`TBLWR_PTR_W-1:0] r;
      r = p;
      unique case (m)
         tblwr_pkg::TBLWR_POSTINC: r = p + 21'h000001;
         tblwr_pkg::TBLWR_POSTDEC: r = p - 21'h000001;
         tblwr_pkg::TBLWR_NOCHG,
         tblwr_pkg::TBLWR_PREINC: r = p;
      endcase
      return r;
   endfunction

   // buffer index is the low pointer bits; the upper bits only pick the
   // row that a later erase and program sequence commits, not kept here
   function automatic logic [`TBLWR_HOLD_AW-1:0] f_hold_index
   (
      logic [`TBLWR_PTR_W-1:0] p
   );
      logic [`TBLWR_HOLD_AW-1:0] idx;
      idx = p[`TBLWR_HOLD_AW-1:0];
      return idx;
   endfunction

   // bit zero picks the half of the program word: clear low, set high
   function automatic logic f_is_high_byte(logic [`TBLWR_PTR_W-1:0] p);
      logic hi;
      hi = p[0];
      return hi;
   endfunction

   assign is_table_write_instr = f_is_table_write(instr_word_i);
   // quarter-phase strobes shared by the state, pointer and latch paths;
   // naming them once keeps the three blocks agreeing on the slots
   assign take = state == tblwr_pkg::TBLWR_IDLE && instr_valid_i
                 && is_table_write_instr;
   assign cyc1_first = state == tblwr_pkg::TBLWR_C1 && q == 2'h0;
   assign latch_slot = state == tblwr_pkg::TBLWR_C2Q1;
   assign hold_addr = f_hold_index(ptr);
   assign busy_o = state != tblwr_pkg::TBLWR_IDLE;
   assign hold_wr_o = state == tblwr_pkg::TBLWR_C2Q4;
   assign table_byte_pointer_o = ptr;
   assign flags_we_o = 1'b0;

   // phase walk, one clock per quarter of an instruction cycle:
   //   take edge   idle, word decoded, mode frozen
   //   cycle one   C1 while q runs 0..3, pre-increment on its first clock
   //   cycle two   C2Q1, then C2Q2 across the second and third quarter,
   //               then C2Q4 for the fourth
   // the latch is captured as the second quarter opens and the holding
   // write lands as C2Q4 closes, so busy stands for eight clocks
   // nothing queues here: the decoder must hold off the next word
   // until busy falls
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
         q <= 2'h0;
      else if (state == tblwr_pkg::TBLWR_IDLE)
         q <= 2'h0;
      else
         q <= q + 2'h1;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
         state <= tblwr_pkg::TBLWR_IDLE;
      else
      begin
         unique case (state)
            tblwr_pkg::TBLWR_IDLE:
               if (take)
                  state <= tblwr_pkg::TBLWR_C1;
            tblwr_pkg::TBLWR_C1:
               if (q == 2'h3)
                  state <= tblwr_pkg::TBLWR_C2Q1;
            tblwr_pkg::TBLWR_C2Q1:
               state <= tblwr_pkg::TBLWR_C2Q2;
            tblwr_pkg::TBLWR_C2Q2:
               if (q == 2'h2)
                  state <= tblwr_pkg::TBLWR_C2Q4;
            tblwr_pkg::TBLWR_C2Q4:
               state <= tblwr_pkg::TBLWR_IDLE;
            // a code outside the one-hot enum can only come from an upset;
            // falling back to idle beats locking up
            default:
               state <= tblwr_pkg::TBLWR_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
         mode <= tblwr_pkg::TBLWR_NOCHG;
      // mode is frozen at decode so a changing word cannot steer the write
      else if (take)
         mode <= f_mode(instr_word_i);
   end

   // latch sampled only in Q2 of cycle two; latch itself never written
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
         data_q <= 8'h00;
      else if (latch_slot)
         data_q <= table_latch_byte_i;
   end

   // pre-increment lands in cycle one so the write sees the new pointer;
   // loads from the register file count only while idle, so a move into
   // the pointer during the two cycles cannot tear the write address
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
         ptr <= `TBLWR_PTR_RST;
      else if (cyc1_first)
         ptr <= f_pre_step(mode, ptr);
      else if (hold_wr_o)
         ptr <= f_post_step(mode, ptr);
      else if (state == tblwr_pkg::TBLWR_IDLE && ptr_load_i)
         ptr <= ptr_load_data_i;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
         hi_byte_o <= 1'b0;
      // reports the half just written, for the decoder's status view
      else if (hold_wr_o)
         hi_byte_o <= f_is_high_byte(ptr);
   end

   // only the buffer is written; no path reaches program memory
   tblwr_hold u_hold
   (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .wr_en_i(hold_wr_o),
      .wr_addr_i(hold_addr),
      .wr_data_i(data_q),
      .rd_addr_i(hold_rd_addr_i),
      .rd_data_o(hold_rd_data_o)
   );
endmodule // tblwr_exec

/* tblwr_map.svh */
// constants for the table-write execution unit
// assumes a 16-bit instruction word and an 8-bit data path
`ifndef TBLWR_MAP_SVH
`define TBLWR_MAP_SVH
`define TBLWR_OPC_FIXED 14'h0003
`define TBLWR_PTR_W 21
`define TBLWR_HOLD_AW 6
`define TBLWR_HOLD_DEPTH 64
`define TBLWR_HOLD_RST 8'hFF
`define TBLWR_PTR_RST 21'h000000
`endif

/* tblwr_pkg.sv */
// types for the table-write execution unit
// assumes tblwr_map.svh supplies the numeric constants
package tblwr_pkg;
   typedef enum logic [1:0] {
      TBLWR_NOCHG = 2'h0,
      TBLWR_POSTINC = 2'h1,
      TBLWR_POSTDEC = 2'h2,
      TBLWR_PREINC = 2'h3
   } tblwr_mode_type;
   typedef enum logic [4:0] {
      TBLWR_IDLE = 5'h01,
      TBLWR_C1 = 5'h02,
      TBLWR_C2Q1 = 5'h04,
      TBLWR_C2Q2 = 5'h08,
      TBLWR_C2Q4 = 5'h10
   } tblwr_state_type;
endpackage

/* tblwr_hold.sv */
// program-flash holding register buffer, byte addressed
// assumes writes come one per cycle from the table-write unit
`timescale 1ns/1ps
`include "tblwr_map.svh"
module tblwr_hold
(
   input wire logic sys_clk_i, // core clock
   input wire logic rst_n_i, // sync reset, active low
   input wire logic wr_en_i, // write strobe
   input wire logic [`TBLWR_HOLD_AW-1:0] wr_addr_i, // byte index
   input wire logic [7:0] wr_data_i, // byte to store
   input wire logic [`TBLWR_HOLD_AW-1:0] rd_addr_i, // read index
   output logic [7:0] rd_data_o // registered read data
);
   logic [7:0] mem [`TBLWR_HOLD_DEPTH];

   genvar g;
   generate
      for (g = 0; g < `TBLWR_HOLD_DEPTH; g++)
      begin : g_byte
         always_ff @(posedge sys_clk_i)
         begin
            if (!rst_n_i)
               mem[g] <= `TBLWR_HOLD_RST;
            else if (wr_en_i && wr_addr_i == g[`TBLWR_HOLD_AW-1:0])
               mem[g] <= wr_data_i;
         end
      end
   endgenerate

   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
         rd_data_o <= 8'h00;
      else
         rd_data_o <= mem[rd_addr_i];
   end
endmodule // tblwr_hold

/* tblwr_checker.sv */
// port assertions for tblwr_exec
// assumes one clock and a sync active-low reset
`timescale 1ns/1ps
module tblwr_checker
(
   input wire logic sys_clk_i, // clk
   input wire logic rst_n_i, // rst
   input wire logic instr_valid_i, // req
   input wire logic [15:0] instr_word_i, // op
   input wire logic [20:0] table_byte_pointer_o, // ptr
   input wire logic busy_o, // busy
   input wire logic hold_wr_o, // write
   input wire logic hi_byte_o, // half
   input wire logic flags_we_o // flags
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   wire logic [1:0] m = instr_word_i[1:0];
   wire logic [20:0] p = table_byte_pointer_o;
   wire logic go = instr_valid_i && !busy_o && instr_word_i[15:2] == 14'h0003;
   chk_write_slot:
   assert property (go |-> ##8 hold_wr_o) else $error("slot");
   chk_busy_span:
   assert property (go |=> busy_o[*8] ##1 !busy_o) else $error("busy");
   chk_flags_quiet:
   assert property (!flags_we_o) else $error("flags");
   chk_ptr_same:
   assert property (go && m == 2'h0 |-> ##9 p == $past(p, 9)) else $error("nc");
   chk_ptr_inc:
   assert property (go && m == 2'h1 |-> ##9 p == $past(p, 9) + 21'h1)
      else $error("inc");
   chk_ptr_dec:
   assert property (go && m == 2'h2 |-> ##8 p == $past(p, 8) ##1
      p == $past(p, 9) - 21'h1) else $error("dec");
   chk_ptr_pre:
   assert property (go && m == 2'h3 |-> ##2 p == $past(p, 2) + 21'h1)
      else $error("pre");
   chk_byte_half:
   assert property (hold_wr_o |=> hi_byte_o == $past(p[0])) else $error("hi");
   cover property (go && m == 2'h3);
   cover property (go && m == 2'h2);
   cover property (hold_wr_o && p[0]);
endmodule // tblwr_checker
bind tblwr_exec tblwr_checker chk (.*);

/* tblwr_flash_model.sv */
// shadow of the flash holding buffer
// assumes the bench stores each byte it expects the unit to write
`timescale 1ns/1ps
module tblwr_flash_model
(
   input wire logic sys_clk_i, // clk
   input wire logic wr_i, // store
   input wire logic [5:0] addr_i, // pointer low bits
   input wire logic [7:0] data_i, // byte
   output logic [7:0] data_o // held byte
);
   logic [7:0] mem [64] = '{default: 8'hFF};
   always_ff @(posedge sys_clk_i)
   begin
      if (wr_i) mem[addr_i] <= data_i;
   end
   assign data_o = mem[addr_i];
endmodule // tblwr_flash_model

/* table_write_execution_tb.sv */
// random bench for tblwr_exec with a shadow buffer
// assumes the checker is bound in its own file
`timescale 1ns/1ps
module table_write_execution_tb;
   logic clk = 0, rst_n = 0, iv = 0, pl = 0, sw = 0;
   logic [15:0] iw = 16'h0000;
   logic [7:0] lat = 8'h00, rd, eb;
   logic [20:0] pd = 21'h000000, ptr;
   logic [5:0] ra = 6'h00;
   logic busy, hw, hi;
   int fail_count = 0, n_tests = 0;
   always #20 clk = ~clk;
   tblwr_exec dut (.sys_clk_i(clk), .rst_n_i(rst_n), .instr_valid_i(iv),
      .instr_word_i(iw), .table_latch_byte_i(lat), .ptr_load_i(pl),
      .ptr_load_data_i(pd), .hold_rd_addr_i(ra), .hold_rd_data_o(rd),
      .table_byte_pointer_o(ptr), .busy_o(busy), .hold_wr_o(hw),
      .hi_byte_o(hi), .flags_we_o());
   tblwr_flash_model model (.sys_clk_i(clk), .wr_i(sw), .addr_i(ra),
      .data_i(lat), .data_o(eb));
   task automatic check(logic [20:0] got, logic [20:0] want);
      n_tests++;
      if (got !== want)
      begin
         $display("Error %0t got %h want %h", $time, got, want);
         fail_count++;
      end
   endtask
   task give_verdict;
      $display("mismatches %0d checks %0d", fail_count, n_tests);
      if (fail_count == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   function automatic logic [20:0] want_ptr(logic ok, logic [1:0] m,
      logic [20:0] q);
      if (!ok || m == 2'h0)
         return q;
      if (m == 2'h2)
         return q - 21'h1;
      return q + 21'h1;
   endfunction
   task automatic run(logic [1:0] m, logic [20:0] q, logic [15:0] op);
      logic ok;
      logic [20:0] a;
      ok = op[15:2] == 14'h0003;
      a = m == 2'h3 ? q + 21'h1 : q;
      @(posedge clk);
      pl <= 1'b1;
      pd <= q;
      lat <= 8'($urandom);
      @(posedge clk);
      pl <= 1'b0;
      iv <= 1'b1;
      iw <= op;
      @(posedge clk);
      // re-offer the word and a pointer load while busy: both refused
      iv <= ok;
      pl <= ok;
      pd <= ~q;
      repeat (7) @(posedge clk);
      iv <= 1'b0;
      pl <= 1'b0;
      @(negedge clk);
      check(hw, ok);
      check(busy, ok);
      @(negedge clk);
      check(busy, 1'b0);
      check(ptr, want_ptr(ok, m, q));
      if (ok) check(hi, a[0]);
      @(posedge clk);
      ra <= a[5:0];
      sw <= ok;
      @(posedge clk);
      sw <= 1'b0;
      @(negedge clk);
      check(rd, eb);
   endtask
   initial
   begin
      void'($urandom(94));
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      run(2'h3, 21'h1FFFFF, 16'h000F);
      run(2'h2, 21'h000000, 16'h000E);
      run(2'h0, 21'h000001, 16'h0008);
      run(2'h1, 21'h1FFFFF, 16'h000D);
      for (int k = 0; k < 24; k++)
         run(2'(k), 21'($urandom), {14'h0003, 2'(k)});
      give_verdict;
   end
   initial
   begin
      #100000;
      fail_count++;
      give_verdict;
   end
endmodule // table_write_execution_tb
